/* rrct_assertions.sv */
// Checker of bus answer timing and frame gating at the ring control ports
`timescale 1ns/1ps
module rrct_checker (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [31:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [3:0]           pstrb,
	input wire logic                 pready,
	input wire logic                 frame_valid,
	input wire rrct_pkg::rrct_port_t frame_port,
	input wire rrct_pkg::rrct_kind_t frame_kind,
	input wire logic                 frame_dst_is_ring_mc,
	input wire logic                 frame_dst_reserved,
	input wire logic                 frame_src_is_supervisor,
	input wire logic                 fwd_valid,
	input wire logic [2:0]           fwd_mask,
	input wire logic                 clear_source_ids
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [15:0] ctl;
	logic        wr_ctl;
	logic        p1f;
	logic        bcn;

	// Committed control writes; the gate rules depend on this copy
	assign wr_ctl = psel && penable && pready && pwrite
		&& paddr == 32'h000001b0 && pstrb[1:0] == 2'h3;
	assign p1f = frame_valid && ctl[1]
		&& frame_port == rrct_pkg::RRCT_PORT_P1;
	assign bcn = frame_kind == rrct_pkg::RRCT_KIND_BEACON;

	// Shadow of the control register, cleared with the block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl <= 16'h0000;
		else if (wr_ctl)
			ctl <= pwdata[15:0];
	end

	property p_pready_setup;
		psel && !penable |=> pready;
	endproperty
	a_pready_setup: assert property (p_pready_setup)
		else $error("no answer");
	property p_pready_one;
		pready |=> !pready;
	endproperty
	a_pready_one: assert property (p_pready_one)
		else $error("long answer");
	property p_fwd;
		frame_valid |=> fwd_valid;
	endproperty
	a_fwd: assert property (p_fwd)
		else $error("frame not answered");
	property p_rx_blk;
		p1f && ctl[3] && frame_kind == rrct_pkg::RRCT_KIND_OTHER
			|=> fwd_mask == 3'h0;
	endproperty
	a_rx_blk: assert property (p_rx_blk)
		else $error("blocked frame passed");
	property p_nbr_host;
		p1f && ctl[3] && frame_kind == rrct_pkg::RRCT_KIND_NBR_CHECK
			&& frame_dst_is_ring_mc |=> fwd_mask[0];
	endproperty
	a_nbr_host: assert property (p_nbr_host)
		else $error("check lost");
	property p_relay;
		p1f && !ctl[2] && bcn |=> fwd_mask[2] && !fwd_mask[1];
	endproperty
	a_relay: assert property (p_relay)
		else $error("beacon not relayed");
	property p_foreign;
		p1f && bcn && !frame_src_is_supervisor |=> fwd_mask[0];
	endproperty
	a_foreign: assert property (p_foreign)
		else $error("foreign beacon lost");
	property p_drop;
		frame_valid && ctl[13] && frame_dst_reserved
			|=> fwd_mask == 3'h0;
	endproperty
	a_drop: assert property (p_drop)
		else $error("reserved passed");
	property p_clr;
		wr_ctl && pwdata[12] |-> ##[1:2] clear_source_ids;
	endproperty
	a_clr: assert property (p_clr)
		else $error("no id clear pulse");
	property p_clr_one;
		clear_source_ids |=> !clear_source_ids;
	endproperty
	a_clr_one: assert property (p_clr_one)
		else $error("long id clear");

	// Main scenarios reached
	c_clr: cover property (wr_ctl && pwdata[12]);
	c_relay: cover property (p1f && !ctl[2] && bcn);
	c_drop: cover property (frame_valid && ctl[13] && frame_dst_reserved);
endmodule

bind rrct_top rrct_checker rrct_checker_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .frame_valid, .frame_port,
	.frame_kind, .frame_dst_is_ring_mc, .frame_dst_reserved,
	.frame_src_is_supervisor, .fwd_valid, .fwd_mask, .clear_source_ids);

/* rrct_defines.svh */
// Offsets, field positions, reset values and timing counts for ring control
`ifndef RRCT_DEFINES_SVH
`define RRCT_DEFINES_SVH

// Register indices; byte address is four times the index
`define RRCT_IDX_RELOAD_LO   8'h68
`define RRCT_IDX_RELOAD_HI   8'h6a
`define RRCT_IDX_CONTROL     8'h6c
`define RRCT_IDX_BCN_TMO_LO  8'h70
`define RRCT_IDX_BCN_TMO_HI  8'h72
`define RRCT_IDX_EVENT       8'h90
`define RRCT_IDX_PIT_COUNT   8'h92
`define RRCT_ADDR_W          10

// Control register fields
`define RRCT_CTL_RESV        0
`define RRCT_CTL_RING_EN     1
`define RRCT_CTL_SUPERVISOR  2
`define RRCT_CTL_P1_RX_BLK   3
`define RRCT_CTL_P1_TX_BLK   4
`define RRCT_CTL_P2_RX_BLK   5
`define RRCT_CTL_P2_TX_BLK   6
`define RRCT_CTL_P1_BCN_HOST 7
`define RRCT_CTL_P2_BCN_HOST 8
`define RRCT_CTL_P1_BTO_EN   9
`define RRCT_CTL_P2_BTO_EN   10
`define RRCT_CTL_PIT_EN      11
`define RRCT_CTL_CLR_IDS     12
`define RRCT_CTL_DROP_RSV    13
`define RRCT_CTL_ANNOUNCE    14
`define RRCT_CTL_WMASK       16'h7ffe

// Event register fields
`define RRCT_EVT_PIT         0
`define RRCT_EVT_PORT1_BEACON_TIMEOUT_FLAG        1
`define RRCT_EVT_PORT2_BEACON_TIMEOUT_FLAG        2

// Reset values
`define RRCT_RST_RELOAD_LO   16'h0000
`define RRCT_RST_RELOAD_HI   16'h0000
`define RRCT_RST_CONTROL     16'h0000

// Forwarding mask bits
`define RRCT_FWD_HOST        0
`define RRCT_FWD_P1          1
`define RRCT_FWD_P2          2

// Timing: counters step at 50 MHz from a 250 MHz clock
`define RRCT_CLK_MHZ         250
`define RRCT_TICK_MHZ        50
`define RRCT_TICK_CYC        (`RRCT_CLK_MHZ / `RRCT_TICK_MHZ)

`endif

/* rrct_pkg.sv */
// Types shared by the ring redundancy control block
package rrct_pkg;
	typedef enum logic [2:0] {
		RRCT_KIND_OTHER,
		RRCT_KIND_BEACON,
		RRCT_KIND_NBR_CHECK,
		RRCT_KIND_LINK_STATUS,
		RRCT_KIND_FAIL_NOTIFY,
		RRCT_KIND_ANNOUNCE
	} rrct_kind_t;

	typedef enum logic [1:0] {
		RRCT_PORT_HOST,
		RRCT_PORT_P1,
		RRCT_PORT_P2,
		RRCT_PORT_NONE
	} rrct_port_t;
endpackage

/* rrct_ring_nbr.sv */
// Ring neighbour model presenting frame descriptors to the gate
`timescale 1ns/1ps
module rrct_ring_nbr (
	input  wire logic            pclk,
	output rrct_pkg::rrct_port_t frame_port,
	output rrct_pkg::rrct_kind_t frame_kind,
	output rrct_pkg::rrct_port_t frame_src_port_field,
	output logic                 frame_valid,
	output logic [2:0]           frame_base_mask,
	output logic [4:0]           frame_flags
);
	// Quiet at time zero
	initial begin
		frame_valid = 1'b0;
		frame_port = rrct_pkg::RRCT_PORT_NONE;
		frame_kind = rrct_pkg::RRCT_KIND_OTHER;
		frame_src_port_field = rrct_pkg::RRCT_PORT_NONE;
		frame_base_mask = 3'h0;
		frame_flags = 5'h00;
	end

	// One descriptor; base mask and flags then flip so stale values never match
	task send(input logic [1:0] p, input logic [2:0] k, input logic [2:0] b,
		input logic [4:0] f, input logic [1:0] s);
		@(posedge pclk);
		frame_valid <= 1'b1;
		frame_port <= rrct_pkg::rrct_port_t'(p);
		frame_kind <= rrct_pkg::rrct_kind_t'(k);
		frame_src_port_field <= rrct_pkg::rrct_port_t'(s);
		frame_base_mask <= b;
		frame_flags <= f;
		@(posedge pclk);
		frame_valid <= 1'b0;
		frame_base_mask <= ~b;
		frame_flags <= ~f;
	endtask
endmodule

/* rrct_top.sv */
// Ring redundancy control registers, interval and beacon timers, frame gate
`timescale 1ns/1ps
`include "rrct_defines.svh"

// How it works
// - Interval timer is a 32-bit down-counter stepping at 50 MHz.
// - Reload value split into low half 0x68 and high half 0x6A.
// - Setting interval enable loads the reload value and starts counting.
// - At zero the interval flag is set and the counter reloads.
// - Ring handling acts only while ring enable is set; beacon timeout counters run without it.
// - Supervisor bit selects supervisor or plain node forwarding.
// - Receive-blocked port drops all frames except listed ring frames.
// - Blocked port still passes neighbour-check/sign-on multicast to host.
// - Blocked port passes status and fail-notify frames addressed to host.
// - Blocked port relays beacons to the other port when not supervisor.
// - Transmit-blocked port sends nothing except listed ring frames.
// - Blocked port sends host beacons as supervisor, host checks by port.
// - Blocked port sends beacons from the other port when not supervisor.
// - Beacon-to-host bit passes beacons; foreign-source beacons always pass.
// - Beacon-timeout enable switches that port's timeout counter on.
// - Writing one to clear-IDs erases source IDs; bit reads back zero.
// - Drop-reserved stops reserved multicast addresses going anywhere.
// - Announce-receive bit delivers announce frames to the host.
// - Beacon counters step at 50 MHz, reload on good beacon, flag at zero.
module rrct_top (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     clk_en,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              paddr,
	input  wire logic [31:0]              pwdata,
	input  wire logic [3:0]               pstrb,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     frame_valid,
	input  wire rrct_pkg::rrct_port_t     frame_port,
	input  wire rrct_pkg::rrct_kind_t     frame_kind,
	input  wire logic [2:0]               frame_base_mask,
	input  wire logic                     frame_dst_is_host,
	input  wire logic                     frame_dst_is_ring_mc,
	input  wire logic                     frame_dst_reserved,
	input  wire logic                     frame_src_is_supervisor,
	input  wire logic                     frame_crc_ok,
	input  wire rrct_pkg::rrct_port_t     frame_src_port_field,
	output logic                          fwd_valid,
	output logic      [2:0]               fwd_mask,
	output logic                          clear_source_ids,
	output logic                          port1_beacon_timeout_flag,
	output logic                          port2_beacon_timeout_flag
);

	// Register state
	logic [15:0] reload_lo, next_reload_lo;
	logic [15:0] reload_hi, next_reload_hi;
	logic [15:0] control, next_control;
	logic [15:0] bcn_tmo_lo, next_bcn_tmo_lo;
	logic [15:0] bcn_tmo_hi, next_bcn_tmo_hi;
	logic [2:0]  event_flags, next_event_flags;
	logic        next_clear_source_ids;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	// Timer state
	logic [2:0]  tick_cnt, next_tick_cnt;
	logic        tick;
	logic [31:0] pit_count, next_pit_count;
	logic        pit_en_d, next_pit_en_d;
	logic        pit_expired;
	logic [1:0]  bto_expired;
	logic [1:0]  bcn_good;
	logic [31:0] pit_reload;
	logic [31:0] bcn_reload;

	// Frame gate state
	logic        next_fwd_valid;
	logic [2:0]  next_fwd_mask;

	// Bus decode
	logic        wr_acc;
	logic        setup;
	logic [7:0]  idx;
	logic [15:0] wdata;

	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pready && pwrite;
	assign idx = paddr[`RRCT_ADDR_W-1:2];
	assign wdata = pwdata[15:0];
	assign pit_reload = {reload_hi, reload_lo};
	assign bcn_reload = {bcn_tmo_hi, bcn_tmo_lo};

	// APB answer: data is captured in setup, so access takes one cycle when clk_en is high at the setup edge
	always_comb begin
		next_pready = 1'b0;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (setup) begin
			next_pready = 1'b1;
			next_prdata = 32'h0000_0000;
			unique case (idx)
				`RRCT_IDX_RELOAD_LO:  next_prdata[15:0] = reload_lo;
				`RRCT_IDX_RELOAD_HI:  next_prdata[15:0] = reload_hi;
				`RRCT_IDX_CONTROL:    next_prdata[15:0] = control;
				`RRCT_IDX_BCN_TMO_LO: next_prdata[15:0] = bcn_tmo_lo;
				`RRCT_IDX_BCN_TMO_HI: next_prdata[15:0] = bcn_tmo_hi;
				`RRCT_IDX_EVENT:      next_prdata[2:0] = event_flags;
				`RRCT_IDX_PIT_COUNT:  next_prdata = pit_count;
				default:              next_pslverr = 1'b1;
			endcase
			// Upper address bits outside the window also miss
			if (paddr[31:`RRCT_ADDR_W] != '0 || paddr[1:0] != 2'b00) begin
				next_pslverr = 1'b1;
				next_prdata = 32'h0000_0000;
			end
			if (pwrite) begin
				next_prdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Register writes; errored accesses change nothing
	always_comb begin
		next_reload_lo = reload_lo;
		next_reload_hi = reload_hi;
		next_control = control;
		next_bcn_tmo_lo = bcn_tmo_lo;
		next_bcn_tmo_hi = bcn_tmo_hi;
		next_clear_source_ids = 1'b0;
		next_control[`RRCT_CTL_CLR_IDS] = 1'b0;
		if (wr_acc && !pslverr && pstrb[1:0] == 2'b11) begin
			unique case (idx)
				`RRCT_IDX_RELOAD_LO:  next_reload_lo = wdata;
				`RRCT_IDX_RELOAD_HI:  next_reload_hi = wdata;
				`RRCT_IDX_CONTROL: begin
					// Reserved bit 0 and bit 15 are never stored
					next_control = wdata & `RRCT_CTL_WMASK;
					next_clear_source_ids = wdata[`RRCT_CTL_CLR_IDS];
					next_control[`RRCT_CTL_CLR_IDS] = 1'b0;
				end
				`RRCT_IDX_BCN_TMO_LO: next_bcn_tmo_lo = wdata;
				`RRCT_IDX_BCN_TMO_HI: next_bcn_tmo_hi = wdata;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_lo <= `RRCT_RST_RELOAD_LO;
			reload_hi <= `RRCT_RST_RELOAD_HI;
			control <= `RRCT_RST_CONTROL;
			bcn_tmo_lo <= 16'h0000;
			bcn_tmo_hi <= 16'h0000;
			clear_source_ids <= 1'b0;
		end else if (clk_en) begin
			reload_lo <= next_reload_lo;
			reload_hi <= next_reload_hi;
			control <= next_control;
			bcn_tmo_lo <= next_bcn_tmo_lo;
			bcn_tmo_hi <= next_bcn_tmo_hi;
			clear_source_ids <= next_clear_source_ids;
		end
	end

	// 50 MHz step from the 250 MHz clock
	always_comb begin
		tick = (tick_cnt == 3'(`RRCT_TICK_CYC - 1));
		next_tick_cnt = tick ? 3'h0 : tick_cnt + 3'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 3'h0;
		end else if (clk_en) begin
			tick_cnt <= next_tick_cnt;
		end
	end

	// Interval timer; a new reload mid-count only shows at the next zero
	always_comb begin
		next_pit_en_d = control[`RRCT_CTL_PIT_EN];
		next_pit_count = pit_count;
		pit_expired = 1'b0;
		if (control[`RRCT_CTL_PIT_EN] && !pit_en_d) begin
			next_pit_count = pit_reload;
		end else if (control[`RRCT_CTL_PIT_EN] && tick) begin
			if (pit_count == 32'h0000_0000) begin
				pit_expired = 1'b1;
				next_pit_count = pit_reload;
			end else begin
				next_pit_count = pit_count - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pit_count <= 32'h0000_0000;
			pit_en_d <= 1'b0;
		end else if (clk_en) begin
			pit_count <= next_pit_count;
			pit_en_d <= next_pit_en_d;
		end
	end

	// Good supervisor beacon per external port restarts its timeout
	always_comb begin
		bcn_good = 2'b00;
		if (frame_valid && frame_kind == rrct_pkg::RRCT_KIND_BEACON &&
		    frame_src_is_supervisor && frame_crc_ok) begin
			bcn_good[0] = (frame_port == rrct_pkg::RRCT_PORT_P1);
			bcn_good[1] = (frame_port == rrct_pkg::RRCT_PORT_P2);
		end
	end

	// Beacon timeout counters, one per external port
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_bto
			logic [31:0] cnt, next_cnt;
			logic        en_d, next_en_d;
			logic        en;

			assign en = control[`RRCT_CTL_P1_BTO_EN + g];

			always_comb begin
				next_en_d = en;
				next_cnt = cnt;
				bto_expired[g] = 1'b0;
				if (en && (!en_d || bcn_good[g])) begin
					next_cnt = bcn_reload;
				end else if (en && tick) begin
					if (cnt == 32'h0000_0000) begin
						bto_expired[g] = 1'b1;
						next_cnt = bcn_reload;
					end else begin
						next_cnt = cnt - 32'h0000_0001;
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt <= 32'h0000_0000;
					en_d <= 1'b0;
				end else if (clk_en) begin
					cnt <= next_cnt;
					en_d <= next_en_d;
				end
			end
		end
	endgenerate

	// Sticky events, write one to clear; a new event wins over the clear
	always_comb begin
		next_event_flags = event_flags;
		if (wr_acc && !pslverr && idx == `RRCT_IDX_EVENT && pstrb[0]) begin
			next_event_flags = event_flags & ~pwdata[2:0];
		end
		if (pit_expired) begin
			next_event_flags[`RRCT_EVT_PIT] = 1'b1;
		end
		if (bto_expired[0]) begin
			next_event_flags[`RRCT_EVT_PORT1_BEACON_TIMEOUT_FLAG] = 1'b1;
		end
		if (bto_expired[1]) begin
			next_event_flags[`RRCT_EVT_PORT2_BEACON_TIMEOUT_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_flags <= 3'h0;
			port1_beacon_timeout_flag <= 1'b0;
			port2_beacon_timeout_flag <= 1'b0;
		end else if (clk_en) begin
			event_flags <= next_event_flags;
			port1_beacon_timeout_flag <= next_event_flags[`RRCT_EVT_PORT1_BEACON_TIMEOUT_FLAG];
			port2_beacon_timeout_flag <= next_event_flags[`RRCT_EVT_PORT2_BEACON_TIMEOUT_FLAG];
		end
	end

	// Frame gate: receive exceptions first, then transmit blocking per port
	always_comb begin
		logic       sup;
		logic       rx_blk;
		logic       bcn_host;
		logic [2:0] m;
		logic       from_host;
		sup = control[`RRCT_CTL_SUPERVISOR];
		rx_blk = 1'b0;
		bcn_host = 1'b0;
		m = frame_base_mask;
		from_host = (frame_port == rrct_pkg::RRCT_PORT_HOST);
		if (frame_port == rrct_pkg::RRCT_PORT_P1) begin
			rx_blk = control[`RRCT_CTL_P1_RX_BLK];
			bcn_host = control[`RRCT_CTL_P1_BCN_HOST];
		end else if (frame_port == rrct_pkg::RRCT_PORT_P2) begin
			rx_blk = control[`RRCT_CTL_P2_RX_BLK];
			bcn_host = control[`RRCT_CTL_P2_BCN_HOST];
		end
		// Without ring enable the base switching decision skips the ring rules; drop-reserved and the ingress-port clear still apply
		if (control[`RRCT_CTL_RING_EN] && !from_host) begin
			unique case (frame_kind)
				rrct_pkg::RRCT_KIND_BEACON: begin
					m = 3'b000;
					m[`RRCT_FWD_HOST] = bcn_host || !frame_src_is_supervisor;
					if (!sup) begin
						m[`RRCT_FWD_P1] = frame_port == rrct_pkg::RRCT_PORT_P2;
						m[`RRCT_FWD_P2] = frame_port == rrct_pkg::RRCT_PORT_P1;
					end
				end
				rrct_pkg::RRCT_KIND_NBR_CHECK: begin
					if (rx_blk) begin
						m = {2'b00, frame_dst_is_ring_mc};
					end
				end
				rrct_pkg::RRCT_KIND_LINK_STATUS,
				rrct_pkg::RRCT_KIND_FAIL_NOTIFY: begin
					if (rx_blk) begin
						m = {2'b00, frame_dst_is_host};
					end
				end
				rrct_pkg::RRCT_KIND_ANNOUNCE: begin
					m[`RRCT_FWD_HOST] = control[`RRCT_CTL_ANNOUNCE];
					if (rx_blk) begin
						m = 3'b000;
					end
				end
				default: begin
					if (rx_blk) begin
						m = 3'b000;
					end
				end
			endcase
		end
		// Transmit blocking on each external egress port
		if (control[`RRCT_CTL_RING_EN]) begin
			if (control[`RRCT_CTL_P1_TX_BLK] && !(
			    (from_host && frame_kind == rrct_pkg::RRCT_KIND_BEACON && sup) ||
			    (from_host && frame_kind == rrct_pkg::RRCT_KIND_NBR_CHECK &&
			     frame_src_port_field == rrct_pkg::RRCT_PORT_P1) ||
			    (!from_host && frame_kind == rrct_pkg::RRCT_KIND_BEACON &&
			     !sup))) begin
				m[`RRCT_FWD_P1] = 1'b0;
			end
			if (control[`RRCT_CTL_P2_TX_BLK] && !(
			    (from_host && frame_kind == rrct_pkg::RRCT_KIND_BEACON && sup) ||
			    (from_host && frame_kind == rrct_pkg::RRCT_KIND_NBR_CHECK &&
			     frame_src_port_field == rrct_pkg::RRCT_PORT_P2) ||
			    (!from_host && frame_kind == rrct_pkg::RRCT_KIND_BEACON &&
			     !sup))) begin
				m[`RRCT_FWD_P2] = 1'b0;
			end
		end
		// Reserved multicast never leaves the ingress port
		if (control[`RRCT_CTL_DROP_RSV] && frame_dst_reserved) begin
			m = 3'b000;
		end
		// A frame never returns through the port it came in on
		if (frame_port != rrct_pkg::RRCT_PORT_NONE) begin
			m[frame_port] = 1'b0;
		end
		next_fwd_valid = frame_valid;
		next_fwd_mask = frame_valid ? m : 3'b000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_valid <= 1'b0;
			fwd_mask <= 3'b000;
		end else if (clk_en) begin
			fwd_valid <= next_fwd_valid;
			fwd_mask <= next_fwd_mask;
		end
	end

endmodule

/* rrct_top_tb.sv */
// Self-checking bench for the ring redundancy control block
`timescale 1ns/1ps
module rrct_top_tb;
	logic                 pclk, presetn, psel, penable, pwrite;
	logic [31:0]          paddr, pwdata, prdata, rdat;
	logic                 pready, pslverr, berr, fwd_valid, frame_valid;
	logic                 clear_source_ids;
	logic                 port1_beacon_timeout_flag, port2_beacon_timeout_flag;
	logic [2:0]           fwd_mask, frame_base_mask;
	logic [4:0]           fl;
	rrct_pkg::rrct_port_t frame_port, sf;
	rrct_pkg::rrct_kind_t frame_kind;
	int                   fail_count, n_checks;

	// Clock enable and strobes tied; the whole word is always written
	rrct_top rrct_top_inst (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
		.frame_valid, .frame_port, .frame_kind, .frame_base_mask,
		.frame_dst_is_host(fl[4]), .frame_dst_is_ring_mc(fl[3]),
		.frame_dst_reserved(fl[2]), .frame_src_is_supervisor(fl[1]),
		.frame_crc_ok(fl[0]), .frame_src_port_field(sf), .fwd_valid,
		.fwd_mask, .clear_source_ids, .port1_beacon_timeout_flag,
		.port2_beacon_timeout_flag);
	rrct_ring_nbr rrct_ring_nbr_inst (.pclk, .frame_port, .frame_kind,
		.frame_src_port_field(sf), .frame_valid, .frame_base_mask,
		.frame_flags(fl));

	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One bus transfer; request held until pready is seen at a rising edge
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the watchdog ends a wait that never sees an answer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		berr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd_chk(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask

	// Control value, then one frame and its gated mask
	task frm(input logic [15:0] c, input logic [1:0] p, input logic [2:0] k,
		input logic [2:0] b, input logic [4:0] f, input logic [1:0] s,
		input logic [2:0] e);
		wr(32'h1b0, {16'h0000, c});
		rrct_ring_nbr_inst.send(p, k, b, f, s);
		#1;
		check({31'h0, fwd_valid}, 32'h1);
		check({29'h0, fwd_mask}, {29'h0, e});
	endtask

	task t_regs;
		rd_chk(32'h1a0, 32'h0);
		rd_chk(32'h1a8, 32'h0);
		rd_chk(32'h1b0, 32'h0);
		wr(32'h1a0, 32'ha5c3);
		wr(32'h1a8, 32'h3c5a);
		rd_chk(32'h1a0, 32'ha5c3);
		rd_chk(32'h1a8, 32'h3c5a);
		wr(32'h1b0, 32'hfffe);
		#1;
		check({31'h0, clear_source_ids}, 32'h1);
		@(posedge pclk);
		#1;
		check({31'h0, clear_source_ids}, 32'h0);
		rd_chk(32'h1b0, 32'h6ffe);
		rd_chk(32'h004, 32'h0);
		check({31'h0, berr}, 32'h1);
		rd_chk(32'h1a2, 32'h0);
		check({31'h0, berr}, 32'h1);
		wr(32'h1b0, 32'h0);
		wr(32'h240, 32'h7);
		rd_chk(32'h240, 32'h0);
		$display("test registers done");
	endtask

	// Reload only changed while the timer is off
	task t_pit;
		wr(32'h1a0, 32'h3);
		wr(32'h1a8, 32'h0);
		repeat (30) @(posedge pclk);
		rd_chk(32'h240, 32'h0);
		wr(32'h1b0, 32'h800);
		repeat (30) @(posedge pclk);
		apb(1'b0, 32'h248, 32'h0);
		check({31'h0, rdat <= 32'h3}, 32'h1);
		rd_chk(32'h240, 32'h1);
		wr(32'h1b0, 32'h0);
		wr(32'h240, 32'h1);
		wr(32'h1b0, 32'h800);
		rd_chk(32'h240, 32'h0);
		wr(32'h1b0, 32'h0);
		wr(32'h240, 32'h1);
		$display("test interval timer done");
	endtask

	task t_bto;
		wr(32'h1c0, 32'h5);
		wr(32'h1c8, 32'h0);
		wr(32'h1b0, 32'h200);
		repeat (40) @(posedge pclk);
		check({31'h0, port1_beacon_timeout_flag}, 32'h1);
		check({31'h0, port2_beacon_timeout_flag}, 32'h0);
		rd_chk(32'h240, 32'h2);
		wr(32'h1b0, 32'h0);
		wr(32'h240, 32'h2);
		wr(32'h1b0, 32'h200);
		// Good beacons faster than the timeout keep it quiet
		repeat (6) begin
			rrct_ring_nbr_inst.send(2'h1, 3'h1, 3'h4, 5'h03, 2'h0);
			repeat (5) @(posedge pclk);
		end
		wr(32'h1b0, 32'h0);
		rd_chk(32'h240, 32'h0);
		$display("test beacon timeout done");
	endtask

	task t_frm;
		frm(16'h000a, 2'h1, 3'h0, 3'h5, 5'h01, 2'h0, 3'h0);
		frm(16'h000a, 2'h1, 3'h2, 3'h5, 5'h09, 2'h0, 3'h1);
		frm(16'h000a, 2'h1, 3'h3, 3'h5, 5'h11, 2'h0, 3'h1);
		frm(16'h000a, 2'h1, 3'h4, 3'h5, 5'h11, 2'h0, 3'h1);
		frm(16'h000a, 2'h1, 3'h1, 3'h7, 5'h03, 2'h0, 3'h4);
		frm(16'h000a, 2'h1, 3'h1, 3'h7, 5'h01, 2'h0, 3'h5);
		frm(16'h000e, 2'h1, 3'h1, 3'h7, 5'h03, 2'h0, 3'h0);
		frm(16'h008e, 2'h1, 3'h1, 3'h7, 5'h03, 2'h0, 3'h1);
		frm(16'h0042, 2'h1, 3'h0, 3'h5, 5'h01, 2'h0, 3'h1);
		frm(16'h0046, 2'h0, 3'h1, 3'h6, 5'h01, 2'h0, 3'h6);
		frm(16'h0052, 2'h0, 3'h2, 3'h6, 5'h09, 2'h2, 3'h4);
		frm(16'h0042, 2'h1, 3'h1, 3'h7, 5'h03, 2'h0, 3'h4);
		frm(16'h2002, 2'h1, 3'h0, 3'h5, 5'h05, 2'h0, 3'h0);
		frm(16'h4002, 2'h1, 3'h5, 3'h4, 5'h01, 2'h0, 3'h5);
		frm(16'h0002, 2'h1, 3'h5, 3'h1, 5'h01, 2'h0, 3'h0);
		frm(16'h0008, 2'h1, 3'h0, 3'h5, 5'h01, 2'h0, 3'h5);
		$display("test frame gate done");
	endtask

	task give_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Reset for six cycles, then every scenario in turn
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		fail_count = 0;
		n_checks = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_pit;
		t_bto;
		t_frm;
		give_verdict;
	end

	// Whole run needs a few hundred cycles; this cuts a hang short
	initial begin
		#100000;
		fail_count++;
		give_verdict;
	end
endmodule
